//--- cmd_defines.vh
// Purpose: Constants for the sensor configuration command decoder
// Assumes: 50 MHz clock
// Notes: Packet type codes, payload lengths, config bit positions
`ifndef CMD_DEFINES_VH
`define CMD_DEFINES_VH

`define PTC_ACCEL_BIAS 8'h84
`define PTC_ACCEL_REF 8'h85
`define PTC_AUTO_ACCEL_REF 8'h86
`define PTC_ZERO_GYROS 8'h87
`define PTC_SELF_TEST 8'h88
`define PTC_START_CAL 8'h89
`define PTC_PROC_COV 8'h8A
`define PTC_MAG_COV 8'h8B
`define PTC_ACCEL_COV 8'h8C
`define PTC_CORR_EN 8'h8D
`define PTC_GYRO_ALIGN 8'h8E
`define PTC_ACCEL_ALIGN 8'h8F
`define PTC_MAG_REF 8'h90
`define PTC_AUTO_MAG_REF 8'h91
`define PTC_MAG_CAL 8'h92
`define PTC_MAG_BIAS 8'h93
`define PTC_GYRO_SCALE 8'h94
`define PTC_RESTART_EST 8'h95

`define LEN_NONE 6'h00
`define LEN_ONE 6'h01
`define LEN_FLOAT 6'h04
`define LEN_VEC16 6'h06
`define LEN_VEC32 6'h0C
`define LEN_MAT 6'h24

`define BIT_START_CAL 0
`define BIT_MAG_EN 0
`define BIT_ACCEL_EN 1
`define RST_START_CAL 1'b1
`define RST_CORR_CFG 8'h03

`define SELF_TEST_MS 570
`define CLOCK_KHZ 50000
`define SELF_TEST_CYCLES (`SELF_TEST_MS * `CLOCK_KHZ)

`endif

//--- payload_mem.v
// Purpose: Byte-addressed store for one packet payload
// Assumes: Payload at most 36 bytes
// Notes: Read data registered
module payload_mem (
  input wire clock,
  input wire wr_en,
  input wire [5:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [5:0] rd_addr,
  output reg [7:0] rd_data_ff
);
  reg [7:0] mem [0:35];

  always @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end
endmodule // payload_mem

//--- cfg_cmd_decoder.v
// Purpose: Decode configuration command packets, update settings
// Assumes: Framing and checksum checked upstream; one byte per pkt_valid
// Notes: Float and matrix words leave as write strobes with an index
// Operation
// - 0x84 six bytes set Z, Y, X accel biases, signed 16-bit
// - 0x85 six bytes set Z, Y, X accel reference vector
// - 0x86 copies latest accel sample to reference, then reports it
// - 0x87 starts gyro bias self-calibration on all three axes
// - Gyro zeroing after power-up unless startup calibration disabled; reset sets the enable back to 1, so zeroing starts after every reset
// - 0x88 runs about 570 ms self-test, then status report
// - 0x89 one byte, bit 0 sets startup calibration enable
// - 0x8A four-byte float sets prediction noise diagonal
// - 0x8B four-byte float sets magnetometer noise diagonal
// - 0x8C four-byte float sets accelerometer noise diagonal
// - 0x8D bit 0 enables magnetometer yaw correction
// - 0x8D bit 1 enables accelerometer pitch and roll correction
// - 0x8E 36 bytes set gyro alignment matrix row by row
// - 0x8F 36 bytes set accel alignment matrix row major
// - 0x90 six bytes set Z, Y, X magnetometer reference
// - 0x91 copies latest mag sample to reference, then reports it
// - 0x92 36 bytes set magnetometer calibration matrix row major
// - 0x93 six bytes set Z, Y, X magnetometer hard-iron bias
// - 0x94 twelve bytes set Z, Y, X gyro scale floats
// - Estimator reset clears state covariance and restarts estimator
// - Zero-length commands have no payload before checksum
`include "cmd_defines.vh"
module cfg_cmd_decoder #(
  parameter [31:0] SELF_TEST_CYCLES = `SELF_TEST_CYCLES
) (
  input wire clock,
  input wire resetn,
  input wire pkt_start,
  input wire [7:0] packet_type_code,
  input wire [5:0] pkt_len,
  input wire pkt_valid,
  input wire [7:0] pkt_byte,
  input wire pkt_good,
  input wire pkt_bad,
  input wire [47:0] accel_sample,
  input wire [47:0] mag_sample,
  input wire gyro_cal_done,
  output reg [47:0] accel_bias_ff,
  output reg [47:0] accel_ref_ff,
  output reg [47:0] mag_ref_ff,
  output reg [47:0] mag_bias_ff,
  output reg start_cal_en_ff,
  output reg [7:0] filter_correction_config_ff,
  output reg mag_corr_en_ff,
  output reg accel_corr_en_ff,
  output reg gyro_cal_start_ff,
  output reg self_test_busy_ff,
  output reg status_report_ff,
  output reg accel_ref_report_ff,
  output reg mag_ref_report_ff,
  output reg restart_estimator_ff,
  output reg word_we_ff,
  output reg [7:0] word_type_ff,
  output reg [3:0] word_idx_ff,
  output reg [31:0] word_data_ff
);
  // ---------------------------------------------------------------
  // Receive and validate
  // ---------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_RECV = 2'h1;
  localparam ST_APPLY = 2'h2;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [7:0] type_ff;
  reg [5:0] len_ff;
  reg [5:0] cnt_ff;
  reg len_ok_ff;
  reg overrun_ff;
  reg [5:0] rd_ptr_ff;
  reg [5:0] rd_left_ff;
  reg rd_pipe_ff;
  reg [31:0] shift_ff;
  reg [1:0] byte_pos_ff;
  reg [31:0] st_cnt_ff;
  reg boot_ff;
  reg [5:0] exp_len;
  reg known;
  wire [7:0] rd_data;

  always @* begin
    known = 1'b1;
    case (packet_type_code)
      `PTC_ACCEL_BIAS, `PTC_ACCEL_REF, `PTC_MAG_REF,
      `PTC_MAG_BIAS: exp_len = `LEN_VEC16;
      `PTC_AUTO_ACCEL_REF, `PTC_ZERO_GYROS, `PTC_SELF_TEST,
      `PTC_AUTO_MAG_REF, `PTC_RESTART_EST: exp_len = `LEN_NONE;
      `PTC_START_CAL, `PTC_CORR_EN: exp_len = `LEN_ONE;
      `PTC_PROC_COV, `PTC_MAG_COV,
      `PTC_ACCEL_COV: exp_len = `LEN_FLOAT;
      `PTC_GYRO_ALIGN, `PTC_ACCEL_ALIGN,
      `PTC_MAG_CAL: exp_len = `LEN_MAT;
      `PTC_GYRO_SCALE: exp_len = `LEN_VEC32;
      default: begin
        exp_len = `LEN_NONE;
        known = 1'b0;
      end
    endcase
  end

  wire store = (state_ff == ST_RECV) && pkt_valid && len_ok_ff &&
    (cnt_ff < len_ff);

  payload_mem u_payload_mem (
    .clock(clock),
    .wr_en(store),
    .wr_addr(cnt_ff),
    .wr_data(pkt_byte),
    .rd_addr(rd_ptr_ff),
    .rd_data_ff(rd_data)
  );

  // ---------------------------------------------------------------
  // Byte count overrun
  // ---------------------------------------------------------------
  // more bytes than the length field
  always @(posedge clock) begin
    if (!resetn) begin
      overrun_ff <= 1'b0;
    end else if (state_ff == ST_IDLE) begin
      overrun_ff <= 1'b0;
    end else if (state_ff == ST_RECV && pkt_valid && cnt_ff == len_ff) begin
      overrun_ff <= 1'b1;
    end
  end

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: if (pkt_start) nxt_state = ST_RECV;
      ST_RECV: begin
        if (pkt_bad) begin
          nxt_state = ST_IDLE;
        end else if (pkt_good) begin
          nxt_state = (len_ok_ff && !overrun_ff && cnt_ff == len_ff) ?
                      ST_APPLY : ST_IDLE;
        end
      end
      ST_APPLY: if (rd_left_ff == 6'h00 && !rd_pipe_ff) nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge clock) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      type_ff <= 8'h00;
      len_ff <= 6'h00;
      cnt_ff <= 6'h00;
      len_ok_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE && pkt_start) begin
        type_ff <= packet_type_code;
        len_ff <= pkt_len;
        cnt_ff <= 6'h00;
        len_ok_ff <= known && (pkt_len == exp_len);
      end else if (store) begin
        cnt_ff <= cnt_ff + 6'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Apply payload
  // ---------------------------------------------------------------
  wire enter_apply = (state_ff == ST_RECV) && (nxt_state == ST_APPLY);
  wire [31:0] shifted = {shift_ff[23:0], rd_data};

  always @(posedge clock) begin
    if (!resetn) begin
      rd_ptr_ff <= 6'h00;
      rd_left_ff <= 6'h00;
      rd_pipe_ff <= 1'b0;
      shift_ff <= 32'h00000000;
      byte_pos_ff <= 2'h0;
      word_we_ff <= 1'b0;
      word_type_ff <= 8'h00;
      word_idx_ff <= 4'h0;
      word_data_ff <= 32'h00000000;
      accel_bias_ff <= 48'h000000000000;
      accel_ref_ff <= 48'h000000000000;
      mag_ref_ff <= 48'h000000000000;
      mag_bias_ff <= 48'h000000000000;
      start_cal_en_ff <= `RST_START_CAL;
      filter_correction_config_ff <= `RST_CORR_CFG;
      mag_corr_en_ff <= 1'b1;
      accel_corr_en_ff <= 1'b1;
      accel_ref_report_ff <= 1'b0;
      mag_ref_report_ff <= 1'b0;
      restart_estimator_ff <= 1'b0;
    end else begin
      word_we_ff <= 1'b0;
      accel_ref_report_ff <= 1'b0;
      mag_ref_report_ff <= 1'b0;
      restart_estimator_ff <= 1'b0;
      rd_pipe_ff <= (rd_left_ff != 6'h00) && state_ff == ST_APPLY;
      if (enter_apply) begin
        rd_ptr_ff <= 6'h00;
        rd_left_ff <= len_ff;
        byte_pos_ff <= 2'h0;
        word_idx_ff <= 4'h0;
        case (type_ff)
          `PTC_AUTO_ACCEL_REF: begin
            accel_ref_ff <= accel_sample;
            accel_ref_report_ff <= 1'b1;
          end
          `PTC_AUTO_MAG_REF: begin
            mag_ref_ff <= mag_sample;
            mag_ref_report_ff <= 1'b1;
          end
          `PTC_RESTART_EST: restart_estimator_ff <= 1'b1;
          default: ;
        endcase
      end else if (state_ff == ST_APPLY && rd_left_ff != 6'h00) begin
        rd_ptr_ff <= rd_ptr_ff + 6'h01;
        rd_left_ff <= rd_left_ff - 6'h01;
      end
      if (rd_pipe_ff) begin
        shift_ff <= shifted;
        byte_pos_ff <= byte_pos_ff + 2'h1;
        case (type_ff)
          `PTC_ACCEL_BIAS: accel_bias_ff <= {accel_bias_ff[39:0], rd_data};
          `PTC_ACCEL_REF: accel_ref_ff <= {accel_ref_ff[39:0], rd_data};
          `PTC_MAG_REF: mag_ref_ff <= {mag_ref_ff[39:0], rd_data};
          `PTC_MAG_BIAS: mag_bias_ff <= {mag_bias_ff[39:0], rd_data};
          `PTC_START_CAL: start_cal_en_ff <= rd_data[`BIT_START_CAL];
          `PTC_CORR_EN: begin
            filter_correction_config_ff <= {6'h00, rd_data[1:0]};
            mag_corr_en_ff <= rd_data[`BIT_MAG_EN];
            accel_corr_en_ff <= rd_data[`BIT_ACCEL_EN];
          end
          default: begin
            if (byte_pos_ff == 2'h3) begin
              word_we_ff <= 1'b1;
              word_type_ff <= type_ff;
              word_data_ff <= shifted;
            end
          end
        endcase
      end
      if (word_we_ff) begin
        word_idx_ff <= word_idx_ff + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Calibration and self-test
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    if (!resetn) begin
      boot_ff <= 1'b1;
      gyro_cal_start_ff <= 1'b0;
      self_test_busy_ff <= 1'b0;
      status_report_ff <= 1'b0;
      st_cnt_ff <= 32'h00000000;
    end else begin
      boot_ff <= 1'b0;
      status_report_ff <= 1'b0;
      if ((boot_ff && start_cal_en_ff) ||
          (enter_apply && type_ff == `PTC_ZERO_GYROS)) begin
        gyro_cal_start_ff <= 1'b1;
      end else if (gyro_cal_done) begin
        gyro_cal_start_ff <= 1'b0;
      end
      if (enter_apply && type_ff == `PTC_SELF_TEST && !self_test_busy_ff) begin
        self_test_busy_ff <= 1'b1;
        st_cnt_ff <= SELF_TEST_CYCLES - 32'h00000001;
      end else if (self_test_busy_ff) begin
        if (st_cnt_ff == 32'h00000000) begin
          self_test_busy_ff <= 1'b0;
          status_report_ff <= 1'b1;
        end else begin
          st_cnt_ff <= st_cnt_ff - 32'h00000001;
        end
      end
    end
  end
endmodule // cfg_cmd_decoder

//--- cfg_cmd_checker.sv
// Purpose: Port assertions for the command decoder
// Assumes: One clock, synchronous active-low reset
// Notes: Bound from the bench top file
module cfg_cmd_checker #(
  parameter [31:0] SELF_TEST_CYCLES = 32'd20
) (
  input wire clock,
  input wire resetn,
  input wire pkt_good,
  input wire gyro_cal_done,
  input wire [7:0] filter_correction_config_ff,
  input wire mag_corr_en_ff,
  input wire accel_corr_en_ff,
  input wire gyro_cal_start_ff,
  input wire self_test_busy_ff,
  input wire status_report_ff,
  input wire accel_ref_report_ff,
  input wire mag_ref_report_ff,
  input wire restart_estimator_ff,
  input wire word_we_ff,
  input wire [3:0] word_idx_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [31:0] busy_cnt_ff;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Cycles spent in the running self-test
  always @(posedge clock) begin
    busy_cnt_ff <= (self_test_busy_ff && resetn) ? busy_cnt_ff + 32'h1 : 32'h0;
  end
  chk_cfg_spare_zero: assert property (
    filter_correction_config_ff[7:2] == 6'h00) else $error("spare bits set");
  chk_mag_en_mirror: assert property (
    mag_corr_en_ff == filter_correction_config_ff[0]) else $error("mag en");
  chk_acc_en_mirror: assert property (
    accel_corr_en_ff == filter_correction_config_ff[1]) else $error("acc en");
  chk_word_idx_range: assert property (
    word_we_ff |-> word_idx_ff <= 4'h8) else $error("word index range");
  chk_pulse_after_good: assert property (
    (accel_ref_report_ff || mag_ref_report_ff || restart_estimator_ff)
    |-> $past(pkt_good)) else $error("pulse without packet end");
  chk_status_one_cycle: assert property (
    status_report_ff |=> !status_report_ff) else $error("status too long");
  chk_status_after_test: assert property (
    $fell(self_test_busy_ff) |-> ##[0:2] status_report_ff)
    else $error("no status after test");
  chk_test_length: assert property (
    $fell(self_test_busy_ff) |-> busy_cnt_ff == SELF_TEST_CYCLES)
    else $error("self-test too short");
  chk_gyro_cal_clear: assert property (
    gyro_cal_done |=> !gyro_cal_start_ff) else $error("gyro cal stuck");
endmodule // cfg_cmd_checker

//--- cmd_host.sv
// Purpose: Host side feeding command packets
// Assumes: Framing and checksum resolved into pulses
// Notes: Bench loads pay before calling send
module cmd_host (
  input wire clock,
  output logic pkt_start,
  output logic [7:0] packet_type_code,
  output logic [5:0] pkt_len,
  output logic pkt_valid,
  output logic [7:0] pkt_byte,
  output logic pkt_good,
  output logic pkt_bad
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] pay [0:35];
  initial begin
    {pkt_start, pkt_valid, pkt_good, pkt_bad} = 4'h0;
    packet_type_code = 8'h00;
    pkt_len = 6'h00;
    pkt_byte = 8'h00;
  end
  task automatic send(input [7:0] t, input [5:0] n, input int nb, input bit bad);
    int i;
    @(negedge clock);
    pkt_start = 1'b1;
    packet_type_code = t;
    pkt_len = n;
    @(negedge clock);
    pkt_start = 1'b0;
    packet_type_code = ~t;
    pkt_len = ~n;
    for (i = 0; i < nb; i++) begin
      pkt_valid = 1'b1;
      pkt_byte = pay[i];
      @(negedge clock);
    end
    pkt_valid = 1'b0;
    pkt_byte = ~pkt_byte;
    pkt_good = !bad;
    pkt_bad = bad;
    @(negedge clock);
    {pkt_good, pkt_bad} = 2'h0;
    repeat (n + 6) @(negedge clock);
  endtask
endmodule // cmd_host

//--- attitude_sensor_config_commands_test.sv
// Purpose: Self-checking bench for the command decoder
// Assumes: Self-test shortened to 20 cycles
// Notes: Host model drives on the falling edge
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module attitude_sensor_config_commands_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [31:0] SELF_TEST_CYCLES = 32'd20;
  logic clock, resetn, gyro_cal_done;
  logic [47:0] accel_sample, mag_sample, e;
  wire pkt_start, pkt_valid, pkt_good, pkt_bad, word_we_ff;
  wire [7:0] packet_type_code, pkt_byte, word_type_ff;
  wire [7:0] filter_correction_config_ff;
  wire [5:0] pkt_len;
  wire [47:0] accel_bias_ff, accel_ref_ff, mag_ref_ff, mag_bias_ff;
  wire start_cal_en_ff, mag_corr_en_ff, accel_corr_en_ff, gyro_cal_start_ff;
  wire self_test_busy_ff, status_report_ff, accel_ref_report_ff;
  wire mag_ref_report_ff, restart_estimator_ff;
  wire [3:0] word_idx_ff;
  wire [31:0] word_data_ff;
  wire [10:0] cfg_all = {start_cal_en_ff, filter_correction_config_ff,
    mag_corr_en_ff, accel_corr_en_ff};
  int n_errors = 0, comparisons = 0, n_st = 0, n_ar = 0, n_mr = 0, n_rs = 0;
  int i, k;
  int wn [7] = '{4, 4, 4, 36, 36, 36, 12};
  logic [7:0] wt [7] = '{8'h8A, 8'h8B, 8'h8C, 8'h8E, 8'h8F, 8'h92, 8'h94};
  logic [7:0] vt [4] = '{8'h84, 8'h85, 8'h90, 8'h93};
  logic [31:0] seed = 32'hD597;
  logic [43:0] words [$];
  logic [7:0] t, v;
  cmd_host host (.*);
  cfg_cmd_decoder #(.SELF_TEST_CYCLES(SELF_TEST_CYCLES)) dut (.*);
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    if (word_we_ff === 1'b1) words.push_back({word_type_ff, word_idx_ff,
      word_data_ff});
    if (status_report_ff === 1'b1) n_st++;
    if (accel_ref_report_ff === 1'b1) n_ar++;
    if (mag_ref_report_ff === 1'b1) n_mr++;
    if (restart_estimator_ff === 1'b1) n_rs++;
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic fill();
    for (int j = 0; j < 36; j++) host.pay[j] = rnd();
  endtask
  function automatic logic [47:0] vec(input [7:0] c);
    case (c)
      8'h84: return accel_bias_ff;
      8'h85: return accel_ref_ff;
      8'h90: return mag_ref_ff;
      default: return mag_bias_ff;
    endcase
  endfunction
  function automatic logic [43:0] wexp(input int j);
    return {t, j[3:0], host.pay[4*j], host.pay[4*j+1], host.pay[4*j+2],
      host.pay[4*j+3]};
  endfunction
  task automatic gyro_done();
    gyro_cal_done = 1'b1;
    @(negedge clock);
    gyro_cal_done = 1'b0;
    @(negedge clock);
    `CHK(gyro_cal_start_ff, 1'b0)
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    gyro_cal_done = 1'b0;
    accel_sample = 48'h0;
    mag_sample = 48'h0;
    repeat (12) @(negedge clock);
    resetn = 1'b1;
    repeat (2) @(negedge clock);
    `CHK(gyro_cal_start_ff, 1'b1)
    `CHK(cfg_all, 11'h40F)
    gyro_done();
    for (k = 0; k < 4; k++) begin
      t = vt[k];
      fill();
      host.send(t, 6'd6, 6, 0);
      e = {host.pay[0], host.pay[1], host.pay[2], host.pay[3], host.pay[4],
        host.pay[5]};
      `CHK(vec(t), e)
      for (i = 0; i < 4; i++) begin
        fill();
        host.send(t, (i == 0) ? 6'd5 : 6'd6, (i == 2) ? 5 : 6 + (i == 3),
          i == 1);
        `CHK(vec(t), e)
      end
    end
    for (i = 0; i < 4; i++) begin
      v = rnd();
      host.pay[0] = {v[7:2], i[1:0]};
      host.send(8'h89, 6'd1, 1, 0);
      host.send(8'h8D, 6'd1, 1, 0);
      `CHK(cfg_all, {i[0], 6'h00, i[1:0], i[0], i[1]})
    end
    accel_sample = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    mag_sample = {accel_sample[31:0], rnd(), rnd()};
    host.send(8'h86, 6'd0, 0, 0);
    host.send(8'h91, 6'd0, 0, 0);
    `CHK({accel_ref_ff, n_ar}, {accel_sample, 32'd1})
    `CHK({mag_ref_ff, n_mr}, {mag_sample, 32'd1})
    for (i = 0; i < 7; i++) begin
      t = wt[i];
      fill();
      words.delete();
      host.send(t, wn[i][5:0], wn[i], 0);
      `CHK(words.size(), wn[i] / 4)
      for (k = 0; k < words.size(); k++) `CHK(words[k], wexp(k))
    end
    host.send(8'h87, 6'd0, 0, 0);
    `CHK(gyro_cal_start_ff, 1'b1)
    gyro_done();
    host.send(8'h88, 6'd0, 0, 0);
    `CHK(self_test_busy_ff, 1'b1)
    host.send(8'h88, 6'd0, 0, 0);
    for (i = 0; i < 200 && self_test_busy_ff !== 1'b0; i++) @(negedge clock);
    if (i == 200) begin
      n_errors++;
      results();
    end
    repeat (3) @(negedge clock);
    `CHK(n_st, 1)
    words.delete();
    host.send(8'h95, 6'd0, 0, 0);
    host.send(8'h95, 6'd1, 1, 0);
    host.send(8'h97, 6'd0, 0, 0);
    `CHK({n_rs, words.size()}, {32'd1, 32'd0})
    results();
  end
endmodule // attitude_sensor_config_commands_test
bind cfg_cmd_decoder cfg_cmd_checker #(.SELF_TEST_CYCLES(SELF_TEST_CYCLES))
  chk (.*);
